//--- adc_conv_model.sv
// converter model: four-phase result handshake and dead time output
// assumes all converter-side polarities active high, as after reset
`timescale 1ns/1ps
module adc_conv_model (
	input  wire logic        aclk,
	input  wire logic        data_taken_ack,
	input  wire logic        result_driver_enable,
	output      logic        conv_data_valid,
	output      logic [15:0] conv_result_bits,
	output      logic        dead_time_in
);
	logic saw_enable;
	logic acked;

	// ----------------------------------------------------------------
	// behaviour
	// ----------------------------------------------------------------
	initial begin
		conv_data_valid <= 1'b0;
		conv_result_bits <= 16'hffff;
		dead_time_in <= 1'b0;
		saw_enable <= 1'b0;
		acked = 1'b0;
	end

	// the enable pulse stands one cycle, so latch it for the bench
	always @(posedge aclk) begin
		if (result_driver_enable)
			saw_enable <= 1'b1;
	end

	task automatic set_dead(input logic lvl);
		@(posedge aclk);
		dead_time_in <= lvl;
	endtask

	// dead: lead with dead time; send: offer a word at all
	task automatic convert(input logic [15:0] v, input logic dead,
		input logic send);
		int n;
		int m;
		saw_enable <= 1'b0;
		acked = 1'b0;
		if (dead) begin
			set_dead(1'b1);
			repeat (30) @(posedge aclk); // lead well over 200 ns
		end
		if (send) begin
			@(posedge aclk);
			conv_result_bits <= ~v; // lines are active low
			conv_data_valid <= 1'b1;
			for (n = 0; n < 40; n++) begin
				@(posedge aclk);
				if (data_taken_ack)
					break;
			end
			conv_data_valid <= 1'b0; // withdraw after ack, or after 40 edges without one
			conv_result_bits <= v; // released lines do not keep the word
			for (m = 0; m < 40; m++) begin
				@(posedge aclk);
				if (!data_taken_ack)
					break;
			end
			acked = (n < 40) && (m < 40);
		end
		if (dead)
			set_dead(1'b0);
	endtask
endmodule

//--- adc_port_pkg.sv
// constants, types and register map of the converter port readout
// assumes a 125 MHz aclk and a 32-bit AXI4-Lite register bus
package adc_port_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ      = 125;
	localparam int unsigned WIN_NS       = 4000;
	localparam int unsigned WIN_CYC      = WIN_NS * CLK_MHZ / 1000;
	localparam int unsigned WAIT_US      = 200;
	localparam int unsigned WAIT_CYC_DEF = WAIT_US * CLK_MHZ;
	localparam int unsigned LIVE_US      = 1000;
	localparam int unsigned LIVE_CYC_DEF = LIVE_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_RESULT = 8'h08;
	localparam logic [7:0] OFF_LIVE   = 8'h0c;
	localparam logic [7:0] OFF_MODNUM = 8'h10;

	// control fields, polarity bit high = signal active high
	localparam int unsigned CB_ARM      = 0;
	localparam int unsigned CB_REJECT   = 1;
	localparam int unsigned CB_POL_VAL  = 2;
	localparam int unsigned CB_POL_ACK  = 3;
	localparam int unsigned CB_POL_DEAD = 4;
	localparam int unsigned CB_POL_ARM  = 5;
	localparam int unsigned CB_POL_DRV  = 6;
	localparam logic [7:0]  CTRL_RST    = 8'h7c;

	localparam logic [6:0] SEG_EIGHT  = 7'h7f;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_DEC   = 2'h3;

	typedef enum logic [1:0] {HS_IDLE, HS_DRIVE, HS_ACK} hs_e;

	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_s;

endpackage

//--- adc_port_readout.sv
// readout of one converter port: handshake, reject window, livetime
// assumes pins sampled on aclk and software on an AXI4-Lite master
//
// Behaviour
// [RQ1] result words are sixteen bits wide
// [RQ2] result input bits are active low, inverted
// [RQ3] valid from converter captures result word
// [RQ4] acknowledge raised after capture
// [RQ5] converter drops valid after acknowledge
// [RQ6] acknowledge dropped once valid is gone
// [RQ7] software polarity for five control signals
// [RQ8] arm output lets converter convert
// [RQ9] driver enable puts results on lines
// [RQ10] reject mode: arm held until event done
// [RQ11] converter: dead time 200 ns before valid
// [RQ12] reject edge in window discards event
// [RQ13] armed indicator shows system is armed
// [RQ14] activity indicator shows transfer or event
// [RQ15] display shows eight, then module number
// [RQ16] dead state forwarded, livetime per millisecond
// [RQ17] captured results passed on to controller
// [RQ18] full port acknowledges but drops new word
// [RQ19] reject mode captures only in open window
// [RQ20] wait for data, zero on timeout
// [RQ21] dead time synchronised before edge detect
// [RQ22] valid input through two-stage synchroniser
// [RQ23] reset: no ack, empty, arm off
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module adc_port_readout #(
	parameter int unsigned WAIT_CYC = adc_port_pkg::WAIT_CYC_DEF,
	parameter int unsigned LIVE_CYC = adc_port_pkg::LIVE_CYC_DEF
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire adc_port_pkg::axi_req_s axi_req,
	output      adc_port_pkg::axi_rsp_s axi_rsp,
	input  wire logic                 conv_data_valid,
	input  wire logic [15:0]          conv_result_bits,
	input  wire logic                 dead_time_in,
	input  wire logic                 reject_in,
	output      logic                 data_taken_ack,
	output      logic                 converter_arm,
	output      logic                 result_driver_enable,
	output      logic                 dead_state,
	output      logic                 armed_led,
	output      logic                 activity_led,
	output      logic [6:0]           seg7
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]             ctrl;
		logic [3:0]             modnum;
		logic                   mod_set;
		adc_port_pkg::hs_e      hs;
		logic [15:0]            result;
		logic                   full;
		logic                   val_s1, val_s2;
		logic                   dead_s1, dead_s2, dead_d;
		logic                   rej_s1, rej_s2, rej_d;
		logic                   win_open;
		logic [8:0]             win_cnt;
		logic                   rejected;
		logic                   wait_on;
		logic [16:0]            wait_cnt;
		logic                   arm_hold;
		logic [16:0]            live_cnt;
		logic [30:0]            live_ms;
		logic                   live_bit;
		logic                   aw_ok, w_ok;
		logic [7:0]             awaddr;
		logic [31:0]            wdata;
		logic [3:0]             wstrb;
		adc_port_pkg::axi_rsp_s rsp;
		logic                   ack_pin, arm_pin, drv_pin, dead_pin;
		logic                   led_arm, led_act;
		logic [6:0]             seg;
	} state_s;

	state_s q, d;

	// segments gfedcba for one decimal digit, blank past nine
	function automatic logic [6:0] seg_of(input logic [3:0] v);
		unique case (v)
			4'h0: seg_of = 7'h3f;
			4'h1: seg_of = 7'h06;
			4'h2: seg_of = 7'h5b;
			4'h3: seg_of = 7'h4f;
			4'h4: seg_of = 7'h66;
			4'h5: seg_of = 7'h6d;
			4'h6: seg_of = 7'h7d;
			4'h7: seg_of = 7'h07;
			4'h8: seg_of = 7'h7f;
			4'h9: seg_of = 7'h6f;
			default: seg_of = 7'h00;
		endcase
	endfunction

	// active levels after polarity, taken from synchronised copies
	logic val_act, dead_act, rej_edge, dead_edge, rej_mode, accept, pop;
	assign val_act   = q.val_s2 ~^ q.ctrl[adc_port_pkg::CB_POL_VAL]; // [RQ7]
	assign dead_act  = q.dead_s2 ~^ q.ctrl[adc_port_pkg::CB_POL_DEAD];
	assign dead_edge = dead_act && !q.dead_d;  // [RQ21]
	assign rej_edge  = q.rej_s2 ^ q.rej_d;
	assign rej_mode  = q.ctrl[adc_port_pkg::CB_REJECT];
	// new words only into an empty port, and in reject mode only in window
	assign accept = !q.full && (!rej_mode || q.win_open);   // [RQ18] [RQ19]
	assign pop = axi_req.arvalid && q.rsp.arready
		&& axi_req.araddr == adc_port_pkg::OFF_RESULT;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] m;
		logic        arm_act;
		m = '0;
		arm_act = 1'b0;
		d = q;
		// two-stage synchronisers, first stage read only by second
		d.val_s1  = conv_data_valid;            // [RQ22]
		d.val_s2  = q.val_s1;
		d.dead_s1 = dead_time_in;               // [RQ21]
		d.dead_s2 = q.dead_s1;
		d.dead_d  = dead_act;
		d.rej_s1  = reject_in;
		d.rej_s2  = q.rej_s1;
		d.rej_d   = q.rej_s2;

		// host takes the word; a set later in this process wins
		if (pop)
			d.full = 1'b0;                  // [RQ17]

		// four-phase handshake with the converter
		unique case (q.hs)
			adc_port_pkg::HS_IDLE: begin
				if (val_act)
					d.hs = adc_port_pkg::HS_DRIVE;
			end
			adc_port_pkg::HS_DRIVE: begin
				// word is dropped, not the handshake, when refused
				if (accept) begin
					d.result = ~conv_result_bits; // [RQ1] [RQ2] [RQ3]
					d.full = 1'b1;
					if (rej_mode)
						d.arm_hold = 1'b1;  // [RQ10]
				end
				d.hs = adc_port_pkg::HS_ACK;    // [RQ4] [RQ18]
			end
			adc_port_pkg::HS_ACK: begin
				if (!val_act)
					d.hs = adc_port_pkg::HS_IDLE;   // [RQ5] [RQ6]
			end
		endcase

		// reject resolving window opened by the dead-time edge
		if (rej_mode && dead_edge && !q.win_open) begin
			d.win_open = 1'b1;
			d.win_cnt  = 9'(adc_port_pkg::WIN_CYC - 1);
			// a reject edge on the opening edge still counts: set wins
			d.rejected = rej_edge;          // [RQ12]
		end else if (q.win_open) begin
			if (rej_edge)
				d.rejected = 1'b1;          // [RQ12]
			if (q.win_cnt == '0) begin
				d.win_open = 1'b0;
				if (q.rejected || rej_edge) begin
					d.full = 1'b0;          // [RQ12]
				end else begin
					d.wait_on  = 1'b1;
					d.wait_cnt = 17'(WAIT_CYC - 1);
				end
			end else begin
				d.win_cnt = q.win_cnt - 9'h001;
			end
		end

		// wait for the word; report zero if it never comes
		if (q.wait_on) begin
			if (q.full) begin
				d.wait_on = 1'b0;
			end else if (q.wait_cnt == '0) begin
				d.wait_on = 1'b0;
				d.result  = 16'h0000;       // [RQ20]
				d.full    = 1'b1;
			end else begin
				d.wait_cnt = q.wait_cnt - 17'h00001;
			end
		end

		// arm released once window, wait and readout are over, or at once when reject mode is off
		if (q.arm_hold && !q.win_open && !q.wait_on && !q.full)
			d.arm_hold = 1'b0;              // [RQ10]
		if (!rej_mode)
			d.arm_hold = 1'b0;

		// livetime image every millisecond
		if (q.live_cnt == '0) begin
			d.live_cnt = 17'(LIVE_CYC - 1);
			d.live_bit = !dead_act;             // [RQ16]
			if (!dead_act)
				d.live_ms = q.live_ms + 31'h00000001;
		end else begin
			d.live_cnt = q.live_cnt - 17'h00001;
		end

		// ------------------------------------------------------------
		// AXI4-Lite write: address and data in either order
		// ------------------------------------------------------------
		if (axi_req.awvalid && q.rsp.awready) begin
			d.aw_ok  = 1'b1;
			d.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && q.rsp.wready) begin
			d.w_ok  = 1'b1;
			d.wdata = axi_req.wdata;
			d.wstrb = axi_req.wstrb;
		end
		if (q.rsp.bvalid && axi_req.bready)
			d.rsp.bvalid = 1'b0;
		if (q.aw_ok && q.w_ok && !q.rsp.bvalid) begin
			d.aw_ok = 1'b0;
			d.w_ok  = 1'b0;
			d.rsp.bvalid = 1'b1;
			d.rsp.bresp  = adc_port_pkg::RESP_OKAY;
			m = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}},
				{8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
			unique case (q.awaddr)
				adc_port_pkg::OFF_CTRL: begin
					d.ctrl = (q.ctrl & ~m[7:0]) | (q.wdata[7:0] & m[7:0]);
				end
				adc_port_pkg::OFF_MODNUM: begin
					if (q.wstrb[0]) begin
						d.modnum  = q.wdata[3:0];
						d.mod_set = 1'b1;   // [RQ15]
					end
				end
				adc_port_pkg::OFF_STATUS, adc_port_pkg::OFF_RESULT,
				adc_port_pkg::OFF_LIVE: begin
					d.rsp.bresp = adc_port_pkg::RESP_OKAY;
				end
				default: d.rsp.bresp = adc_port_pkg::RESP_DEC;
			endcase
		end
		// one write at a time: each ready only while its own channel is not parked and no response waits
		d.rsp.awready = !d.aw_ok && !d.rsp.bvalid;
		d.rsp.wready  = !d.w_ok && !d.rsp.bvalid;

		// ------------------------------------------------------------
		// AXI4-Lite read, answered one edge after the address
		// ------------------------------------------------------------
		if (q.rsp.rvalid && axi_req.rready)
			d.rsp.rvalid = 1'b0;
		if (axi_req.arvalid && q.rsp.arready) begin
			d.rsp.rvalid = 1'b1;
			d.rsp.rresp  = adc_port_pkg::RESP_OKAY;
			d.rsp.rdata  = '0;
			unique case (axi_req.araddr)
				adc_port_pkg::OFF_CTRL:   d.rsp.rdata = {24'h0, q.ctrl};
				adc_port_pkg::OFF_STATUS: d.rsp.rdata = {24'h0, q.full,
					q.win_open, q.wait_on, q.rejected, dead_act,
					q.hs != adc_port_pkg::HS_IDLE, q.arm_pin ~^
					q.ctrl[adc_port_pkg::CB_POL_ARM], q.mod_set};
				adc_port_pkg::OFF_RESULT: d.rsp.rdata = {q.full, 15'h0,
					q.result};              // [RQ17]
				adc_port_pkg::OFF_LIVE:   d.rsp.rdata = {q.live_bit,
					q.live_ms};             // [RQ16]
				adc_port_pkg::OFF_MODNUM: d.rsp.rdata = {27'h0, q.mod_set,
					q.modnum};
				default: d.rsp.rresp = adc_port_pkg::RESP_DEC;
			endcase
		end
		d.rsp.arready = !d.rsp.rvalid;

		// pins, each a flip-flop; ack, arm and driver pins carry their own polarity
		arm_act = q.ctrl[adc_port_pkg::CB_ARM] && !d.arm_hold;   // [RQ8]
		d.ack_pin = (d.hs == adc_port_pkg::HS_ACK)
			~^ q.ctrl[adc_port_pkg::CB_POL_ACK];             // [RQ4] [RQ7]
		d.arm_pin = arm_act ~^ q.ctrl[adc_port_pkg::CB_POL_ARM];
		d.drv_pin = (d.hs == adc_port_pkg::HS_DRIVE)
			~^ q.ctrl[adc_port_pkg::CB_POL_DRV];             // [RQ9]
		d.dead_pin = dead_act;                                   // [RQ16]
		d.led_arm  = q.ctrl[adc_port_pkg::CB_ARM];               // [RQ13]
		d.led_act  = d.full || d.win_open || d.wait_on;          // [RQ14]
		d.seg = d.mod_set ? seg_of(d.modnum) : adc_port_pkg::SEG_EIGHT;
	end

	// ----------------------------------------------------------------
	// register, synchronous active-low reset
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;                            // [RQ23]
			q.ctrl <= adc_port_pkg::CTRL_RST;
			q.hs <= adc_port_pkg::HS_IDLE;
			q.seg <= adc_port_pkg::SEG_EIGHT;   // [RQ15]
			q.rsp.awready <= 1'b1;
			q.rsp.wready <= 1'b1;
			q.rsp.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign axi_rsp              = q.rsp;
	assign data_taken_ack       = q.ack_pin;
	assign converter_arm        = q.arm_pin;
	assign result_driver_enable = q.drv_pin;
	assign dead_state           = q.dead_pin;
	assign armed_led            = q.led_arm;
	assign activity_led         = q.led_act;
	assign seg7                 = q.seg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic ack_act, arm_out_act;
	assign ack_act = data_taken_ack ~^ q.ctrl[adc_port_pkg::CB_POL_ACK];
	assign arm_out_act = converter_arm ~^ q.ctrl[adc_port_pkg::CB_POL_ARM];

	sequence s_valid_seen;
		q.hs == adc_port_pkg::HS_IDLE && val_act;
	endsequence
	sequence s_acked;
		q.hs == adc_port_pkg::HS_ACK && ack_act;
	endsequence

	a_ack_after_valid: assert property ( // [RQ4]
		s_valid_seen |=> ##1 s_acked)
		else $error("acknowledge not raised two edges after valid");
	a_ack_release: assert property ( // [RQ6]
		(s_acked and !val_act) |=> (!ack_act && q.hs == adc_port_pkg::HS_IDLE))
		else $error("acknowledge held after valid was withdrawn");
	a_capture_inverts: assert property ( // [RQ2]
		(q.hs == adc_port_pkg::HS_DRIVE && accept)
		|=> (q.full && q.result == ~$past(conv_result_bits)))
		else $error("captured word is not the inverted input");
	a_full_keeps_old: assert property ( // [RQ18]
		(q.hs == adc_port_pkg::HS_DRIVE && q.full && !pop)
		|=> ($stable(q.result) ##1 s_acked))
		else $error("full port overwrote or skipped acknowledge");
	a_reject_gates: assert property ( // [RQ19]
		(q.hs == adc_port_pkg::HS_DRIVE && rej_mode && !q.win_open
		&& !q.full) |=> !q.full)
		else $error("word taken with reject window closed");
	a_arm_held: assert property ( // [RQ10]
		(q.hs == adc_port_pkg::HS_DRIVE && accept && rej_mode)
		|=> !arm_out_act [*2])
		else $error("converter armed right after a reject-mode capture");
	a_window_open: assert property ( // [RQ12]
		(rej_mode && dead_edge && !q.win_open) |=> q.win_open [*8])
		else $error("reject window did not open on dead-time edge");
	a_wait_zero: assert property ( // [RQ20]
		(q.wait_on && q.wait_cnt == '0 && !q.full)
		|=> (q.full && q.result == 16'h0000))
		else $error("timeout did not report a zero word");

endmodule

//--- test_adc_port_readout.sv
// self-checking bench of the converter port readout
// assumes the converter model beside it and shortened wait/live counts
`timescale 1ns/1ps
module test_adc_port_readout_reject;
	localparam int unsigned WAIT_T = 20;
	localparam int unsigned LIVE_T = 50;
	logic                   aclk;
	logic                   aresetn;
	logic                   reject_in;
	adc_port_pkg::axi_req_s axi_req;
	adc_port_pkg::axi_rsp_s axi_rsp;
	logic                   valid_w;
	logic [15:0]            bits_w;
	logic                   dead_w;
	logic                   ack_w;
	logic                   arm_w;
	logic                   drv_w;
	logic                   dead_state;
	logic                   armed_led;
	logic                   activity_led;
	logic [6:0]             seg7;
	logic [31:0]            rd;
	logic [1:0]             rsp;
	int                     miscompares;
	int                     tests_run;
	int                     cyc;

	adc_port_readout #(.WAIT_CYC(WAIT_T), .LIVE_CYC(LIVE_T)) DUT (
		.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
		.axi_rsp(axi_rsp), .conv_data_valid(valid_w),
		.conv_result_bits(bits_w), .dead_time_in(dead_w),
		.reject_in(reject_in), .data_taken_ack(ack_w),
		.converter_arm(arm_w), .result_driver_enable(drv_w),
		.dead_state(dead_state), .armed_led(armed_led),
		.activity_led(activity_led), .seg7(seg7));

	adc_conv_model conv (
		.aclk(aclk), .data_taken_ack(ack_w),
		.result_driver_enable(drv_w), .conv_data_valid(valid_w),
		.conv_result_bits(bits_w), .dead_time_in(dead_w));

	// ----------------------------------------------------------------
	// bench helpers
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// cycle counter, an int so it starts at zero by itself
	always @(posedge aclk) cyc <= cyc + 1;

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// each bus task opens on a fresh edge so no signal is set twice
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		axi_req.awaddr <= a;
		axi_req.awvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hf;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (aw_ok && w_ok && axi_rsp.bvalid)
				break;
			if (!aw_ok && axi_rsp.awready) begin
				aw_ok = 1'b1;
				axi_req.awvalid <= 1'b0;
			end
			if (!w_ok && axi_rsp.wready) begin
				w_ok = 1'b1;
				axi_req.wvalid <= 1'b0;
			end
		end
		axi_req.bready <= 1'b0;
		rsp = axi_rsp.bresp;
		if (n == 50) begin
			miscompares++;
			print_verdict();
		end
	endtask

	task automatic axi_read(input logic [7:0] a);
		int n;
		@(posedge aclk);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (axi_rsp.rvalid)
				break;
			if (axi_rsp.arready)
				axi_req.arvalid <= 1'b0;
		end
		axi_req.rready <= 1'b0;
		rd = axi_rsp.rdata;
		rsp = axi_rsp.rresp;
		if (n == 50) begin
			miscompares++;
			print_verdict();
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_and_bus();
		check({25'h0, seg7}, 32'h7f); // eight after power-up
		check({30'h0, ack_w, arm_w}, 32'h0); // idle handshake pins
		axi_read(adc_port_pkg::OFF_STATUS);
		check(rd, 32'h0); // nothing held after reset
		axi_write(8'h20, 32'h1);
		check({30'h0, rsp}, {30'h0, adc_port_pkg::RESP_DEC});
		axi_read(8'h20);
		check({rd[29:0], rsp}, {30'h0, adc_port_pkg::RESP_DEC});
		axi_read(adc_port_pkg::OFF_CTRL);
		check(rd, {24'h0, adc_port_pkg::CTRL_RST}); // polarity defaults
	endtask

	task automatic t_arm_polarity();
		axi_write(adc_port_pkg::OFF_CTRL, 32'h7d);
		repeat (3) @(posedge aclk);
		check({30'h0, armed_led, arm_w}, 32'h3); // armed, arm on
		axi_write(adc_port_pkg::OFF_CTRL, 32'h55);
		repeat (3) @(posedge aclk);
		check({30'h0, ack_w, arm_w}, 32'h2); // inverted ack and arm
		axi_write(adc_port_pkg::OFF_CTRL, 32'h7d);
	endtask

	task automatic t_capture(input logic [15:0] v);
		conv.convert(v, 1'b0, 1'b1);
		check({30'h0, conv.acked, conv.saw_enable}, 32'h3);
		axi_read(adc_port_pkg::OFF_RESULT);
		check(rd, {16'h8000, v}); // inverted 16-bit word
		axi_read(adc_port_pkg::OFF_RESULT);
		check({31'h0, rd[31]}, 32'h0); // popped word leaves port empty
	endtask

	task automatic t_full_drop();
		conv.convert(16'h00aa, 1'b0, 1'b1);
		conv.convert(16'h0055, 1'b0, 1'b1);
		check({31'h0, conv.acked}, 32'h1); // second word still acked
		axi_read(adc_port_pkg::OFF_RESULT);
		check(rd, 32'h8000_00aa); // old word kept
	endtask

	task automatic t_live_display();
		int n;
		int t0;
		logic [31:0] l0;
		@(posedge aclk);
		t0 = cyc;
		axi_read(adc_port_pkg::OFF_LIVE);
		l0 = rd;
		for (n = 0; n < 600; n++) begin
			if (cyc >= t0 + 500)
				break;
			@(posedge aclk);
		end
		if (n == 600) begin
			miscompares++;
			print_verdict();
		end
		axi_read(adc_port_pkg::OFF_LIVE);
		check({rd[31], rd[30:0] - l0[30:0]}, 32'h8000_000a);
		conv.set_dead(1'b1);
		repeat (6) @(posedge aclk);
		check({31'h0, dead_state}, 32'h1); // synchronised dead
		conv.set_dead(1'b0);
		axi_write(adc_port_pkg::OFF_MODNUM, 32'h3);
		repeat (3) @(posedge aclk);
		check({25'h0, seg7}, 32'h4f); // digit three shown
		axi_read(adc_port_pkg::OFF_MODNUM);
		check(rd, 32'h13); // number set and kept
	endtask

	// window 500 cycles plus wait of WAIT_T, with margin
	task automatic t_reject();
		axi_write(adc_port_pkg::OFF_CTRL, 32'h7f);
		conv.convert(16'h0777, 1'b1, 1'b1);
		check({30'h0, activity_led, conv.acked}, 32'h3);
		repeat (600) @(posedge aclk);
		check({31'h0, arm_w}, 32'h0); // arm held while word waits
		axi_read(adc_port_pkg::OFF_RESULT);
		check(rd, 32'h8000_0777); // captured inside window
		repeat (4) @(posedge aclk);
		check({31'h0, arm_w}, 32'h1); // arm released after readout
		conv.convert(16'h0333, 1'b1, 1'b1);
		reject_in <= ~reject_in;
		repeat (600) @(posedge aclk);
		axi_read(adc_port_pkg::OFF_RESULT);
		check({31'h0, rd[31]}, 32'h0); // rejected event discarded
		conv.convert(16'h0000, 1'b1, 1'b0);
		repeat (600) @(posedge aclk);
		axi_read(adc_port_pkg::OFF_RESULT);
		check(rd, 32'h8000_0000); // zero reported on timeout
		conv.convert(16'h0999, 1'b0, 1'b1);
		axi_read(adc_port_pkg::OFF_RESULT);
		check({31'h0, rd[31]}, 32'h0); // closed window drops word
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		miscompares = 0;
		tests_run = 0;
		axi_req <= '0;
		aresetn <= 1'b0;
		reject_in <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_and_bus();
		t_arm_polarity();
		t_capture(16'hffff);
		t_capture(16'h8001);
		t_full_drop();
		t_live_display();
		t_reject();
		print_verdict();
	end
endmodule
